// ===== hdl/asrs_pkg.sv
// shared constants and types for the converter setup register slice
package asrs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int CH_N   = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_MODE   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_GAIN   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_RSVD   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h9;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [DATA_W-1:0] MODE_RST  = 16'h0510;
    localparam logic [DATA_W-1:0] CLOCK_RST = 16'h030E;
    localparam logic [DATA_W-1:0] GAIN_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] RSVD_RST  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int MODE_FMT_BIT = 0;
    localparam int MODE_HIZ_BIT = 1;
    localparam int MODE_SEL_LSB = 2;
    localparam int CLK_PWR_LSB  = 0;
    localparam int CLK_OSR_LSB  = 2;
    localparam int CLK_TBM_BIT  = 5;
    localparam int CLK_EN_LSB   = 8;
    localparam int CLK_RW_W     = 10;
    localparam int GAIN_CH0_LSB = 0;
    localparam int GAIN_CH1_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // oversampling ratios
    localparam logic [15:0] OSR_FIXED = 16'h0040;
    localparam logic [15:0] OSR_TABLE [8] = '{16'h0080, 16'h0100, 16'h0200, 16'h0400,
                                              16'h0800, 16'h1000, 16'h2000, 16'h3F80};

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status layout
    localparam int EV_W   = 3;
    localparam int EV_CH0 = 0;
    localparam int EV_PIN = 2;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_NS    = 8;
    localparam int PULSE_NS  = 40;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W     = 3;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {SRC_LAG, SRC_OR, SRC_LEAD} asrs_src_e;
    typedef enum logic [1:0] {PWR_VLOW, PWR_LOW, PWR_HIRES} asrs_power_e;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asrs_bus_s;

    typedef struct packed {
        logic [CH_N-1:0] ch_on;
        logic [15:0]     osr;
        asrs_power_e     power;
        logic [7:0]      gain_one;
        logic [7:0]      gain_zero;
    } asrs_cfg_s;

endpackage : asrs_pkg

// ===== hdl/asrs_pin_drive.sv
// ready pin driver: level hold or fixed-length low pulse, idle high or float
`timescale 1ns/1ps
`default_nettype none
module asrs_pin_drive
(
    input  wire logic mclk,       // system clock
    input  wire logic reset,      // sync reset, active high
    input  wire logic fire,       // one-cycle ready event
    input  wire logic hold,       // ready level for held format
    input  wire logic pulse_mode, // 1: fixed low pulse
    input  wire logic idle_float, // 1: float when idle
    output logic      pin_out,    // pin level
    output logic      pin_oe_n    // low while driving
);
    import asrs_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_out;
    logic             next_oe_n;
    logic             active;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_cnt = cnt;
        if (pulse_mode && fire)
        begin
            next_cnt = CNT_W'(PULSE_CYC);
        end
        else if (cnt != '0)
        begin
            next_cnt = cnt - CNT_W'(1);
        end
        active    = pulse_mode ? (next_cnt != '0) : hold;
        next_out  = !active;
        // idle state: drive high or release
        next_oe_n = active ? 1'b0 : idle_float;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cnt      <= '0;
            pin_out  <= 1'b1;
            pin_oe_n <= 1'b0;
        end
        else
        begin
            cnt      <= next_cnt;
            pin_out  <= next_out;
            pin_oe_n <= next_oe_n;
        end
    end

endmodule : asrs_pin_drive
`default_nettype wire

// ===== hdl/asrs_setup_regs.sv
// setup register slice: mode, clocking, gain, reserved, ready pin, interrupt
`timescale 1ns/1ps
`default_nettype none
module asrs_setup_regs
(
    input  wire logic                       mclk,                  // system clock
    input  wire logic                       reset,                 // sync reset, active high
    input  wire asrs_pkg::asrs_bus_s        bus,                   // register request
    output logic [asrs_pkg::DATA_W-1:0]     rdata,                 // read data, next cycle
    input  wire logic [asrs_pkg::CH_N-1:0]  ch_ready,              // per-channel result pulse
    input  wire logic                       data_read,             // results taken by host
    output asrs_pkg::asrs_cfg_s             settings,              // decoded converter setup
    output logic                            result_ready_pin_out,  // ready pin level
    output logic                            result_ready_pin_oe_n, // ready pin enable, low drives
    output logic                            irq                    // level interrupt
);
    import asrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic hit(input asrs_bus_s b, input logic [ADDR_W-1:0] a);
        return b.addr == a;
    endfunction : hit

    function automatic asrs_src_e src_of(input logic [1:0] code);
        asrs_src_e s;
        unique case (code)
            2'h0: s = SRC_LAG;
            2'h1: s = SRC_OR;
            2'h2: s = SRC_LEAD;
            2'h3: s = SRC_LEAD;
        endcase
        return s;
    endfunction : src_of

    function automatic asrs_power_e power_of(input logic [1:0] code);
        asrs_power_e p;
        unique case (code)
            2'h0: p = PWR_VLOW;
            2'h1: p = PWR_LOW;
            2'h2: p = PWR_HIRES;
            2'h3: p = PWR_HIRES;
        endcase
        return p;
    endfunction : power_of

    function automatic logic [7:0] gain_of(input logic [2:0] code);
        return 8'h01 << code;
    endfunction : gain_of

    function automatic logic [15:0] osr_of(input logic fixed_ratio_override, input logic [2:0] code);
        return fixed_ratio_override ? OSR_FIXED : OSR_TABLE[code];
    endfunction : osr_of

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [DATA_W-1:0]   mode;
    logic [CLK_RW_W-1:0] clk_reg;
    logic [DATA_W-1:0]   gain;
    logic [DATA_W-1:0]   rsvd;
    logic [EV_W-1:0]     status;
    logic [EV_W-1:0]     mask;
    logic [CH_N-1:0]     pend;
    logic [CH_N-1:0]     pe_prev;

    logic [DATA_W-1:0]   next_mode;
    logic [CLK_RW_W-1:0] next_clk_reg;
    logic [DATA_W-1:0]   next_gain;
    logic [DATA_W-1:0]   next_rsvd;
    logic [EV_W-1:0]     next_status;
    logic [EV_W-1:0]     next_mask;
    logic [CH_N-1:0]     next_pend;
    logic [DATA_W-1:0]   next_rdata;
    logic                next_irq;
    asrs_cfg_s           next_settings;

    logic [CH_N-1:0]     ch_en;
    logic [CH_N-1:0]     arrive;
    logic [CH_N-1:0]     pe;
    logic                all_rdy;
    logic                any_rdy;
    logic                all_prev;
    logic                any_prev;
    logic                hold;
    logic                fire;
    asrs_src_e           src;
    logic [DATA_W-1:0]   rd_val;

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    always_comb
    begin
        next_mode    = mode;
        next_clk_reg = clk_reg;
        next_gain    = gain;
        next_rsvd    = rsvd;
        next_mask    = mask;
        if (bus.wr)
        begin
            if (hit(bus, ADDR_MODE))
            begin
                next_mode = bus.wdata;
            end
            if (hit(bus, ADDR_CLOCK))
            begin
                // top six bits are not stored, so they read zero
                next_clk_reg = bus.wdata[CLK_RW_W-1:0];
            end
            if (hit(bus, ADDR_GAIN))
            begin
                next_gain = bus.wdata;
            end
            if (hit(bus, ADDR_RSVD))
            begin
                next_rsvd = bus.wdata;
            end
            if (hit(bus, ADDR_MASK))
            begin
                next_mask = bus.wdata[EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero

    always_comb
    begin
        unique case (bus.addr)
            ADDR_MODE:   rd_val = mode;
            ADDR_CLOCK:  rd_val = {{(DATA_W-CLK_RW_W){1'b0}}, clk_reg};
            ADDR_GAIN:   rd_val = gain;
            ADDR_RSVD:   rd_val = rsvd;
            ADDR_STATUS: rd_val = {{(DATA_W-EV_W){1'b0}}, status};
            ADDR_MASK:   rd_val = {{(DATA_W-EV_W){1'b0}}, mask};
            default:     rd_val = '0;
        endcase
        next_rdata = bus.rd ? rd_val : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel readiness and ready pin source

    always_comb
    begin
        ch_en  = clk_reg[CLK_EN_LSB +: CH_N];
        arrive = ch_ready & ch_en;
        // arrival wins over a host read in the same cycle
        for (int i = 0; i < CH_N; i++)
        begin
            next_pend[i] = (pend[i] & !data_read) | arrive[i];
        end
        pe       = pend & ch_en;
        all_rdy  = (ch_en != '0) && (pe == ch_en);
        any_rdy  = (pe != '0);
        all_prev = (ch_en != '0) && ((pe_prev & ch_en) == ch_en);
        any_prev = ((pe_prev & ch_en) != '0);
        src      = src_of(mode[MODE_SEL_LSB +: 2]);
        // enum has an unused code; defaults keep the process free of latches
        hold     = 1'b0;
        fire     = 1'b0;
        unique case (src)
            SRC_LAG:
            begin
                hold = all_rdy;
                fire = all_rdy && !all_prev;
            end
            SRC_OR:
            begin
                hold = any_rdy;
                fire = ((pe & ~pe_prev) != '0);
            end
            SRC_LEAD:
            begin
                hold = any_rdy;
                fire = any_rdy && !any_prev;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: read clears, new events win over the clear

    always_comb
    begin
        next_status = status;
        if (bus.rd && hit(bus, ADDR_STATUS))
        begin
            next_status = '0;
        end
        next_status[EV_CH0 +: CH_N] = next_status[EV_CH0 +: CH_N] | arrive;
        next_status[EV_PIN]         = next_status[EV_PIN] | fire;
        next_irq                    = ((next_status & next_mask) != '0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded settings, taken from next values so they track writes in one cycle

    always_comb
    begin
        next_settings.ch_on     = next_clk_reg[CLK_EN_LSB +: CH_N];
        next_settings.osr       = osr_of(next_clk_reg[CLK_TBM_BIT],
                                         next_clk_reg[CLK_OSR_LSB +: 3]);
        next_settings.power     = power_of(next_clk_reg[CLK_PWR_LSB +: 2]);
        next_settings.gain_one  = gain_of(next_gain[GAIN_CH1_LSB +: 3]);
        next_settings.gain_zero = gain_of(next_gain[GAIN_CH0_LSB +: 3]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mode    <= MODE_RST;
            clk_reg <= CLOCK_RST[CLK_RW_W-1:0];
            gain    <= GAIN_RST;
            rsvd    <= RSVD_RST;
            status  <= '0;
            mask    <= '0;
            pend    <= '0;
            pe_prev <= '0;
            rdata   <= '0;
            irq     <= 1'b0;
            settings.ch_on     <= CLOCK_RST[CLK_EN_LSB +: CH_N];
            settings.osr       <= OSR_TABLE[CLOCK_RST[CLK_OSR_LSB +: 3]];
            settings.power     <= PWR_HIRES;
            settings.gain_one  <= gain_of(GAIN_RST[GAIN_CH1_LSB +: 3]);
            settings.gain_zero <= gain_of(GAIN_RST[GAIN_CH0_LSB +: 3]);
        end
        else
        begin
            mode     <= next_mode;
            clk_reg  <= next_clk_reg;
            gain     <= next_gain;
            rsvd     <= next_rsvd;
            status   <= next_status;
            mask     <= next_mask;
            pend     <= next_pend;
            pe_prev  <= pe;
            rdata    <= next_rdata;
            irq      <= next_irq;
            settings <= next_settings;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ready pin

    asrs_pin_drive u_pin
    (
        .mclk       (mclk),
        .reset      (reset),
        .fire       (fire),
        .hold       (hold),
        .pulse_mode (mode[MODE_FMT_BIT]),
        .idle_float (mode[MODE_HIZ_BIT]),
        .pin_out    (result_ready_pin_out),
        .pin_oe_n   (result_ready_pin_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_mode_reset_val: assert property ($fell(reset) |-> mode == MODE_RST)
        else $error("mode register not at reset value");

    a_clock_top_zero: assert property (bus.rd && hit(bus, ADDR_CLOCK)
        |=> rdata[DATA_W-1:CLK_RW_W] == '0)
        else $error("clocking register top bits not zero");

    a_chan_disable: assert property (bus.wr && hit(bus, ADDR_CLOCK)
        |=> settings.ch_on == $past(bus.wdata[CLK_EN_LSB +: CH_N]))
        else $error("channel enables do not follow write");

    a_osr_override: assert property (bus.wr && hit(bus, ADDR_CLOCK)
        && bus.wdata[CLK_TBM_BIT] |=> settings.osr == OSR_FIXED)
        else $error("override did not force ratio 64");

    a_osr_code: assert property (bus.wr && hit(bus, ADDR_CLOCK)
        && !bus.wdata[CLK_TBM_BIT] && bus.wdata[CLK_OSR_LSB +: 3] == 3'h7
        |=> settings.osr == 16'h3F80)
        else $error("ratio code 7 not decoded");

    a_power_hires: assert property (bus.wr && hit(bus, ADDR_CLOCK)
        && bus.wdata[CLK_PWR_LSB +: 2] == 2'h3 |=> settings.power == PWR_HIRES)
        else $error("power code 3 not high-resolution");

    a_gain_one: assert property (bus.wr && hit(bus, ADDR_GAIN)
        |=> settings.gain_one == (8'h01 << $past(bus.wdata[GAIN_CH1_LSB +: 3])))
        else $error("channel one gain wrong");

    a_gain_zero: assert property (bus.wr && hit(bus, ADDR_GAIN)
        |=> settings.gain_zero == (8'h01 << $past(bus.wdata[GAIN_CH0_LSB +: 3])))
        else $error("channel zero gain wrong");

    a_rsvd_readback: assert property (bus.wr && hit(bus, ADDR_RSVD)
        ##1 bus.rd && hit(bus, ADDR_RSVD) |=> rdata == $past(bus.wdata, 2))
        else $error("reserved register lost write");

    a_lag_waits: assert property (!mode[MODE_FMT_BIT] && src == SRC_LAG
        && ch_en == 2'h3 && pe != 2'h3 |=> result_ready_pin_out)
        else $error("pin low before last channel");

    a_or_level: assert property (!mode[MODE_FMT_BIT] && src == SRC_OR
        && pe != '0 |=> !result_ready_pin_out && !result_ready_pin_oe_n)
        else $error("pin not low with a channel ready");

    a_lead_level: assert property (!mode[MODE_FMT_BIT] && src == SRC_LEAD
        && pe != '0 |=> !result_ready_pin_out)
        else $error("pin not low after first channel");

    a_idle_float: assert property (result_ready_pin_oe_n
        |-> $past(mode[MODE_HIZ_BIT]) && result_ready_pin_out)
        else $error("pin released while not set to float");

    a_pulse_len: assert property (fire && mode[MODE_FMT_BIT]
        |=> !result_ready_pin_out [*5])
        else $error("ready pulse shorter than fixed length");

    a_irq_level: assert property (irq == ((status & mask) != '0))
        else $error("interrupt does not match masked status");

endmodule : asrs_setup_regs
`default_nettype wire

// ===== bench/asrs_host_model.sv
// host side model: register bus master and result acknowledge
`timescale 1ns/1ps
`default_nettype none
module asrs_host_model
(
    input  wire logic                         mclk,      // system clock
    output asrs_pkg::asrs_bus_s               bus,       // register request
    input  wire logic [asrs_pkg::DATA_W-1:0]  rdata,     // read data
    output logic                              data_read  // results taken
);
    import asrs_pkg::*;

    initial
    begin
        bus       = '0;
        data_read = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // released address and data lines carry the inverse, except wr_rd, which keeps the ~d wdata of its read strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'hA5A5};
        @(posedge mclk);
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'h5A5A};
        #1;
        d = rdata;
    endtask : rd

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         output logic [DATA_W-1:0] q);
        @(posedge mclk);
        bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~d};
        @(posedge mclk);
        bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        #1;
        q = rdata;
    endtask : wr_rd

    task automatic ack();
        @(posedge mclk);
        data_read <= 1'b1;
        @(posedge mclk);
        data_read <= 1'b0;
    endtask : ack
endmodule : asrs_host_model
`default_nettype wire

// ===== bench/asrs_setup_regs_bench.sv
// self-checking bench for the setup register slice
`timescale 1ns/1ps
`default_nettype none
module asrs_setup_regs_bench;
    import asrs_pkg::*;

    logic        mclk     = 1'b0;
    logic        reset    = 1'b1;
    logic [1:0]  ch_ready = 2'b00;
    logic        data_read;
    asrs_bus_s   bus;
    logic [15:0] rdata;
    asrs_cfg_s   cfg;
    logic        pin;
    logic        oe_n;
    logic        irq;
    logic [15:0] r;
    int          err_count = 0;
    int          n_checks  = 0;
    logic [15:0] exp_osr [8] = '{16'h0080, 16'h0100, 16'h0200, 16'h0400,
                                 16'h0800, 16'h1000, 16'h2000, 16'h3F80};

    always #4 mclk = ~mclk;

    asrs_setup_regs dut_u (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
        .ch_ready(ch_ready), .data_read(data_read), .settings(cfg),
        .result_ready_pin_out(pin), .result_ready_pin_oe_n(oe_n), .irq(irq));
    asrs_host_model host_u (.mclk(mclk), .bus(bus), .rdata(rdata), .data_read(data_read));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic rchk(input string name, input logic [3:0] a, input logic [15:0] exp);
        host_u.rd(a, r);
        chk(name, r, exp);
    endtask : rchk

    task automatic wrs(input logic [3:0] a, input logic [15:0] d);
        host_u.wr(a, d);
        @(posedge mclk);
        #1;
    endtask : wrs

    // pin reacts two edges after the event, so three edges are allowed
    task automatic pulse(input logic [1:0] m);
        @(posedge mclk);
        ch_ready <= m;
        @(posedge mclk);
        ch_ready <= 2'b00;
        repeat (3) @(posedge mclk);
        #1;
    endtask : pulse

    task automatic clear_pend();
        host_u.ack();
        repeat (3) @(posedge mclk);
        #1;
    endtask : clear_pend

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("pin", {15'h0, pin}, 16'h0001);
        chk("oe_n", {15'h0, oe_n}, 16'h0000);
        chk("ch_on", {14'h0, cfg.ch_on}, 16'h0003);
        chk("osr", cfg.osr, 16'h0400);
        chk("power", {14'h0, cfg.power}, 16'h0002);
        chk("amplifier_gain_select", {8'h0, cfg.gain_one}, 16'h0001);
        chk("gain0", {8'h0, cfg.gain_zero}, 16'h0001);
        rchk("mode", 4'h2, 16'h0510);
        rchk("clock", 4'h3, 16'h030E);
        rchk("gain", 4'h4, 16'h0000);
        rchk("rsvd", 4'h5, 16'h0000);
        rchk("unmapped", 4'hF, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_clock();
        wrs(4'h3, 16'hFFFF);
        rchk("clock_ro", 4'h3, 16'h03FF);
        chk("osr_fix", cfg.osr, 16'h0040);
        for (int i = 0; i < 8; i++)
        begin
            wrs(4'h3, 16'h0100 | 16'(i << 2) | 16'(i % 4));
            chk("osr", cfg.osr, exp_osr[i]);
            chk("power", {14'h0, cfg.power}, (i % 4 == 3) ? 16'h0002 : 16'(i % 4));
            chk("ch_on", {14'h0, cfg.ch_on}, 16'h0001);
        end
        $display("test clock done");
    endtask : t_clock

    task automatic t_gain();
        for (int i = 0; i < 8; i++)
        begin
            wrs(4'h4, 16'(i << 4) | 16'(7 - i));
            chk("amplifier_gain_select", {8'h0, cfg.gain_one}, 16'(1 << i));
            chk("gain0", {8'h0, cfg.gain_zero}, 16'(1 << (7 - i)));
        end
        rchk("gain_rb", 4'h4, 16'h0070);
        $display("test gain done");
    endtask : t_gain

    task automatic t_rsvd();
        host_u.wr_rd(4'h5, 16'hC3A5, r);
        chk("rsvd_rb", r, 16'hC3A5);
        wrs(4'h5, 16'h0000);
        host_u.wr_rd(4'h2, 16'h051F, r);
        chk("mode_rb", r, 16'h051F);
        $display("test rsvd done");
    endtask : t_rsvd

    task automatic t_pin();
        wrs(4'h3, 16'h030E);
        wrs(4'h2, 16'h0510);
        pulse(2'b01);
        chk("lag_one", {15'h0, pin}, 16'h0001);
        pulse(2'b10);
        chk("lag_all", {15'h0, pin}, 16'h0000);
        clear_pend();
        chk("idle_hi", {15'h0, pin}, 16'h0001);
        wrs(4'h2, 16'h0514);
        pulse(2'b01);
        chk("or_any", {15'h0, pin}, 16'h0000);
        clear_pend();
        for (int s = 2; s < 4; s++)
        begin
            wrs(4'h2, 16'h0510 | 16'(s << 2));
            pulse(2'b10);
            chk("lead", {15'h0, pin}, 16'h0000);
            clear_pend();
        end
        // only channel one enabled: a channel zero event must not count
        wrs(4'h3, 16'h020E);
        wrs(4'h2, 16'h0510);
        pulse(2'b01);
        chk("off_ch", {15'h0, pin}, 16'h0001);
        pulse(2'b10);
        chk("lag_en", {15'h0, pin}, 16'h0000);
        clear_pend();
        wrs(4'h3, 16'h030E);
        wrs(4'h2, 16'h0512);
        chk("float", {15'h0, oe_n}, 16'h0001);
        pulse(2'b11);
        chk("drive", {14'h0, oe_n, pin}, 16'h0000);
        clear_pend();
        chk("float2", {15'h0, oe_n}, 16'h0001);
        wrs(4'h2, 16'h0515);
        pulse(2'b01);
        chk("pls_lo", {15'h0, pin}, 16'h0000);
        repeat (4) @(posedge mclk);
        #1;
        chk("pls_end", {15'h0, pin}, 16'h0001);
        pulse(2'b10);
        chk("or_pls2", {15'h0, pin}, 16'h0000);
        clear_pend();
        // leading source pulses only for the first channel
        wrs(4'h2, 16'h0519);
        pulse(2'b01);
        repeat (4) @(posedge mclk);
        pulse(2'b10);
        chk("lead_pls1", {15'h0, pin}, 16'h0001);
        clear_pend();
        $display("test pin done");
    endtask : t_pin

    task automatic t_irq();
        wrs(4'h2, 16'h0510);
        wrs(4'h9, 16'h0007);
        host_u.rd(4'h8, r);
        pulse(2'b01);
        chk("irq_set", {15'h0, irq}, 16'h0001);
        host_u.rd(4'h8, r);
        chk("status", r, 16'h0001);
        chk("irq_clr", {15'h0, irq}, 16'h0000);
        rchk("status0", 4'h8, 16'h0000);
        pulse(2'b10);
        rchk("status_pin", 4'h8, 16'h0006);
        clear_pend();
        wrs(4'h9, 16'h0000);
        pulse(2'b01);
        chk("irq_mask", {15'h0, irq}, 16'h0000);
        clear_pend();
        $display("test irq done");
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // whole run is a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_clock();
        t_gain();
        t_rsvd();
        t_pin();
        t_irq();
        tally_and_finish();
    end
endmodule : asrs_setup_regs_bench
`default_nettype wire
